// *** core/spcpb_pkg.sv ***
// Constants and types of the servo pulse command parameter bank
//
// Contract
// - Flag deviation overflow above threshold in pulse/sequence modes
// - Threshold in ten-pulse units, 1 to 12800000
// - Pulse input debounce, 16.6666 ns steps, default 30 (the code rounds each step up to 4 clocks, 20 ns)
// - Direction input debounce, same steps, default 30
// - Output mode 0 drives assigned output functions
// - Output mode 1 reports sequence progress status
// - Return to mode 0 restores prior assignments
// - Deviation-clear input zeroes accumulated deviation
// - Clear trigger: 0 rising edge, 1 level
// - Clear trigger works only in linear control
// - Three extra gear numerators, chosen by selects
// - Option 1: ramp down, then hold standstill position
package spcpb_pkg;
	// Parameter addresses
	localparam logic [15:0] ADDR_DEV_LIMIT = 16'h0346;
	localparam logic [15:0] ADDR_PULSE_FLT = 16'h0348;
	localparam logic [15:0] ADDR_DIR_FLT = 16'h034A;
	localparam logic [15:0] ADDR_OUT_MODE = 16'h0358;
	localparam logic [15:0] ADDR_CLR_TRIG = 16'h0364;
	localparam logic [15:0] ADDR_GEAR_TWO = 16'h0378;
	localparam logic [15:0] ADDR_GEAR_THREE = 16'h037A;
	localparam logic [15:0] ADDR_GEAR_FOUR = 16'h037C;
	localparam logic [15:0] ADDR_SPECIAL_ONE = 16'h0382;
	// Reset values and ranges
	localparam logic [31:0] RST_DEV_LIMIT = 32'h0005DC00;
	localparam logic [31:0] MIN_DEV_LIMIT = 32'h00000001;
	localparam logic [31:0] MAX_DEV_LIMIT = 32'h00C35000;
	localparam logic [8:0] RST_FILTER_STEPS = 9'h01E;
	localparam logic [31:0] RST_GEAR = 32'h00000080;
	localparam logic [31:0] MIN_GEAR = 32'h00000001;
	localparam logic [31:0] MAX_GEAR = 32'h1FFFFFFF;
	localparam logic [15:0] RST_SPECIAL_ONE = 16'h0200;
	localparam logic [15:0] SPECIAL_ONE_RSVD = 16'h003F;
	localparam int ZHOLD_OPT_BIT = 10;
	localparam logic [15:0] CTRL_LINEAR = 16'h4001;
	localparam logic [3:0] DEV_UNIT_PULSES = 4'hA;
	// Debounce step: 16.6666 ns in units of 0.1 ps, clock 5 ns
	localparam int FILTER_STEP_100FS = 166666;
	localparam int CLK_PERIOD_100FS = 50000;
	localparam int FILTER_STEP_CYC =
		(FILTER_STEP_100FS + CLK_PERIOD_100FS - 1) / CLK_PERIOD_100FS;
	localparam int FILTER_CNT_W = 12;
	// Operating modes
	typedef enum logic [3:0] {
		SPCPB_MODE_PT = 4'h1,
		SPCPB_MODE_PS = 4'h2,
		SPCPB_MODE_V = 4'h4,
		SPCPB_MODE_T = 4'h8
	} spcpb_mode_t;
	// Zero-speed hold states
	typedef enum logic [2:0] {
		SPCPB_ZH_IDLE = 3'h1,
		SPCPB_ZH_RAMP = 3'h2,
		SPCPB_ZH_LOCK = 3'h4
	} spcpb_zh_t;
endpackage

// *** core/spcpb_debounce.sv ***
// Three-stage pin synchroniser followed by a stable-time filter
`timescale 1ns/1ps
module spcpb_debounce #(
	parameter int CNT_W = spcpb_pkg::FILTER_CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin and setting
	input wire logic pinIn,
	input wire logic [8:0] filterSteps,
	// Filtered level
	output logic levelOut
);
	logic sync1_r, sync2_r, sync3_r;
	logic [CNT_W-1:0] stableCnt_r;
	logic [CNT_W-1:0] limit;

	assign limit = CNT_W'(filterSteps * spcpb_pkg::FILTER_STEP_CYC);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= pinIn;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Counter restarts whenever the candidate level disagrees
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stableCnt_r <= '0;
			levelOut <= 1'b0;
		end else if (sync2_r != sync3_r || sync3_r == levelOut) begin
			stableCnt_r <= '0;
		end else if (stableCnt_r >= limit) begin
			levelOut <= sync3_r;
			stableCnt_r <= '0;
		end else begin
			stableCnt_r <= stableCnt_r + 1'b1;
		end
	end
endmodule

// *** core/spcpb_dout_select.sv ***
// Digital output source selection between assigned functions and sequence status
`timescale 1ns/1ps
module spcpb_dout_select #(
	parameter int OUT_N = 6
) (
	// Mode
	input wire logic seqMode,
	// Sources
	input wire logic [OUT_N-1:0] assignedFunc,
	input wire logic [OUT_N-1:0] seqStatus,
	// Selected pattern
	output logic [OUT_N-1:0] outSel
);
	// Assignments live outside and are never overwritten, so mode 0 restores them
	genvar i;
	generate
		for (i = 0; i < OUT_N; i++) begin : g_out
			assign outSel[i] = seqMode ? seqStatus[i] : assignedFunc[i];
		end
	endgenerate
endmodule

// *** core/spcpb_bank.sv ***
// Servo pulse command parameter bank with deviation monitor and output steering
`timescale 1ns/1ps
module spcpb_bank #(
	parameter int OUT_N = 6,
	parameter int DEV_W = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Parameter access port
	input wire logic parWr,
	input wire logic parRd,
	input wire logic [15:0] parAddr,
	input wire logic [31:0] parWdata,
	output logic [31:0] parRdata_r,
	output logic parAck_r,
	output logic parErr_r,
	// Pulse command interface pins
	input wire logic pulseCmdPin,
	input wire logic dirCmdPin,
	input wire logic deviationClearPin,
	input wire logic gearSelLowPin,
	input wire logic gearSelHighPin,
	input wire logic zeroSpeedHoldPin,
	// Drive state, same clock
	input wire logic [3:0] opMode,
	input wire logic [15:0] controlModeSelect,
	input wire logic fbStep,
	input wire logic fbDir,
	input wire logic faultReset,
	input wire logic standstill,
	input wire logic [31:0] actualPosition,
	input wire logic [31:0] gearNumeratorOne,
	input wire logic [OUT_N-1:0] assignedFunc,
	input wire logic [OUT_N-1:0] seqStatus,
	// Drive outputs
	output logic deviationOverflowError_r,
	output logic [DEV_W-1:0] positionDeviation_r,
	output logic [31:0] activeGearNumerator_r,
	output logic [OUT_N-1:0] digitalOutput_r,
	output logic rampStopReq_r,
	output logic positionLock_r,
	output logic [31:0] holdPosition_r
);
	logic [31:0] devLimit_r;
	logic [8:0] pulseFilter_r;
	logic [8:0] dirFilter_r;
	logic seqOutMode_r;
	logic clrLevelMode_r;
	logic [31:0] gearTwo_r;
	logic [31:0] gearThree_r;
	logic [31:0] gearFour_r;
	logic [15:0] specialOne_r;

	logic pulseLvl, dirLvl, clrLvl, gselLo, gselHi, zhLvl;
	logic pulsePrev_r, clrPrev_r;
	logic [OUT_N-1:0] outSel;
	spcpb_pkg::spcpb_zh_t zhState_r;

	// Filter settings are fixed: software sees them but cannot change them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulseFilter_r <= spcpb_pkg::RST_FILTER_STEPS;
			dirFilter_r <= spcpb_pkg::RST_FILTER_STEPS;
		end else begin
			pulseFilter_r <= pulseFilter_r;
			dirFilter_r <= dirFilter_r;
		end
	end

	spcpb_debounce u_pulse_flt (
		.clk(clk),
		.rst(rst),
		.pinIn(pulseCmdPin),
		.filterSteps(pulseFilter_r),
		.levelOut(pulseLvl)
	);

	spcpb_debounce u_dir_flt (
		.clk(clk),
		.rst(rst),
		.pinIn(dirCmdPin),
		.filterSteps(dirFilter_r),
		.levelOut(dirLvl)
	);

	// Other inputs get the synchroniser with no extra filtering
	spcpb_debounce u_clr_sync (
		.clk(clk),
		.rst(rst),
		.pinIn(deviationClearPin),
		.filterSteps(9'h000),
		.levelOut(clrLvl)
	);

	spcpb_debounce u_gsl_sync (
		.clk(clk),
		.rst(rst),
		.pinIn(gearSelLowPin),
		.filterSteps(9'h000),
		.levelOut(gselLo)
	);

	spcpb_debounce u_gsh_sync (
		.clk(clk),
		.rst(rst),
		.pinIn(gearSelHighPin),
		.filterSteps(9'h000),
		.levelOut(gselHi)
	);

	spcpb_debounce u_zh_sync (
		.clk(clk),
		.rst(rst),
		.pinIn(zeroSpeedHoldPin),
		.filterSteps(9'h000),
		.levelOut(zhLvl)
	);

	// Write decode with range checks
	logic wrOk;
	always_comb begin
		wrOk = 1'b0;
		if (parAddr == spcpb_pkg::ADDR_DEV_LIMIT) begin
			wrOk = parWdata >= spcpb_pkg::MIN_DEV_LIMIT &&
				parWdata <= spcpb_pkg::MAX_DEV_LIMIT;
		end else if (parAddr == spcpb_pkg::ADDR_OUT_MODE) begin
			wrOk = parWdata[31:1] == '0;
		end else if (parAddr == spcpb_pkg::ADDR_CLR_TRIG) begin
			wrOk = parWdata[31:1] == '0;
		end else if (parAddr == spcpb_pkg::ADDR_GEAR_TWO ||
				parAddr == spcpb_pkg::ADDR_GEAR_THREE ||
				parAddr == spcpb_pkg::ADDR_GEAR_FOUR) begin
			wrOk = parWdata >= spcpb_pkg::MIN_GEAR &&
				parWdata <= spcpb_pkg::MAX_GEAR;
		end else if (parAddr == spcpb_pkg::ADDR_SPECIAL_ONE) begin
			wrOk = parWdata[31:16] == '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			devLimit_r <= spcpb_pkg::RST_DEV_LIMIT;
			seqOutMode_r <= 1'b0;
			clrLevelMode_r <= 1'b0;
			gearTwo_r <= spcpb_pkg::RST_GEAR;
			gearThree_r <= spcpb_pkg::RST_GEAR;
			gearFour_r <= spcpb_pkg::RST_GEAR;
			specialOne_r <= spcpb_pkg::RST_SPECIAL_ONE;
		end else if (parWr && wrOk) begin
			if (parAddr == spcpb_pkg::ADDR_DEV_LIMIT) begin
				devLimit_r <= parWdata;
			end else if (parAddr == spcpb_pkg::ADDR_OUT_MODE) begin
				seqOutMode_r <= parWdata[0];
			end else if (parAddr == spcpb_pkg::ADDR_CLR_TRIG) begin
				clrLevelMode_r <= parWdata[0];
			end else if (parAddr == spcpb_pkg::ADDR_GEAR_TWO) begin
				gearTwo_r <= parWdata;
			end else if (parAddr == spcpb_pkg::ADDR_GEAR_THREE) begin
				gearThree_r <= parWdata;
			end else if (parAddr == spcpb_pkg::ADDR_GEAR_FOUR) begin
				gearFour_r <= parWdata;
			end else if (parAddr == spcpb_pkg::ADDR_SPECIAL_ONE) begin
				// Reserved low bits are kept at zero whatever is written
				specialOne_r <= parWdata[15:0] & ~spcpb_pkg::SPECIAL_ONE_RSVD;
			end
		end
	end

	// Read mux
	logic [31:0] rdVal;
	logic rdHit;
	always_comb begin
		rdVal = 32'h00000000;
		rdHit = 1'b1;
		if (parAddr == spcpb_pkg::ADDR_DEV_LIMIT) begin
			rdVal = devLimit_r;
		end else if (parAddr == spcpb_pkg::ADDR_PULSE_FLT) begin
			rdVal = {23'h000000, pulseFilter_r};
		end else if (parAddr == spcpb_pkg::ADDR_DIR_FLT) begin
			rdVal = {23'h000000, dirFilter_r};
		end else if (parAddr == spcpb_pkg::ADDR_OUT_MODE) begin
			rdVal = {31'h00000000, seqOutMode_r};
		end else if (parAddr == spcpb_pkg::ADDR_CLR_TRIG) begin
			rdVal = {31'h00000000, clrLevelMode_r};
		end else if (parAddr == spcpb_pkg::ADDR_GEAR_TWO) begin
			rdVal = gearTwo_r;
		end else if (parAddr == spcpb_pkg::ADDR_GEAR_THREE) begin
			rdVal = gearThree_r;
		end else if (parAddr == spcpb_pkg::ADDR_GEAR_FOUR) begin
			rdVal = gearFour_r;
		end else if (parAddr == spcpb_pkg::ADDR_SPECIAL_ONE) begin
			rdVal = {16'h0000, specialOne_r};
		end else begin
			rdHit = 1'b0;
		end
	end

	// One-cycle answer; error on unmapped, read-only or out-of-range access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			parRdata_r <= 32'h00000000;
			parAck_r <= 1'b0;
			parErr_r <= 1'b0;
		end else begin
			parAck_r <= parRd || parWr;
			parErr_r <= (parRd && !rdHit) || (parWr && !wrOk);
			if (parRd && rdHit) begin
				parRdata_r <= rdVal;
			end
		end
	end

	// Deviation accumulator
	logic cmdStep, clrFire, inPosMode;
	logic [DEV_W-1:0] devMag;
	logic [35:0] devLimitPulses;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulsePrev_r <= 1'b0;
			clrPrev_r <= 1'b0;
		end else begin
			pulsePrev_r <= pulseLvl;
			clrPrev_r <= clrLvl;
		end
	end

	assign cmdStep = pulseLvl && !pulsePrev_r;
	assign clrFire = controlModeSelect == spcpb_pkg::CTRL_LINEAR &&
		(clrLevelMode_r ? clrLvl : (clrLvl && !clrPrev_r));
	assign inPosMode = opMode == spcpb_pkg::SPCPB_MODE_PT ||
		opMode == spcpb_pkg::SPCPB_MODE_PS;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			positionDeviation_r <= '0;
		end else if (clrFire) begin
			positionDeviation_r <= '0;
		end else begin
			positionDeviation_r <= positionDeviation_r
				+ (cmdStep ? (dirLvl ? '1 : DEV_W'(1)) : '0)
				- (fbStep ? (fbDir ? '1 : DEV_W'(1)) : '0);
		end
	end

	assign devMag = positionDeviation_r[DEV_W-1] ? DEV_W'(0) - positionDeviation_r
		: positionDeviation_r;
	assign devLimitPulses = 36'(devLimit_r * spcpb_pkg::DEV_UNIT_PULSES);

	// Sticky error; a new overflow beats the fault reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			deviationOverflowError_r <= 1'b0;
		end else if (inPosMode && 36'(devMag) > devLimitPulses) begin
			deviationOverflowError_r <= 1'b1;
		end else if (faultReset) begin
			deviationOverflowError_r <= 1'b0;
		end
	end

	// Gear numerator selection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			activeGearNumerator_r <= spcpb_pkg::RST_GEAR;
		end else begin
			case ({gselHi, gselLo})
				2'b01: activeGearNumerator_r <= gearTwo_r;
				2'b10: activeGearNumerator_r <= gearThree_r;
				2'b11: activeGearNumerator_r <= gearFour_r;
				default: activeGearNumerator_r <= gearNumeratorOne;
			endcase
		end
	end

	// Digital outputs
	spcpb_dout_select #(
		.OUT_N(OUT_N)
	) u_dout (
		.seqMode(seqOutMode_r),
		.assignedFunc(assignedFunc),
		.seqStatus(seqStatus),
		.outSel(outSel)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			digitalOutput_r <= '0;
		end else begin
			digitalOutput_r <= outSel;
		end
	end

	// Zero-speed hold: option 1 ramps first, option 0 locks at once
	logic zhRampOpt;
	assign zhRampOpt = specialOne_r[spcpb_pkg::ZHOLD_OPT_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zhState_r <= spcpb_pkg::SPCPB_ZH_IDLE;
			rampStopReq_r <= 1'b0;
			positionLock_r <= 1'b0;
			holdPosition_r <= 32'h00000000;
		end else begin
			case (zhState_r)
				spcpb_pkg::SPCPB_ZH_IDLE: begin
					if (zhLvl && zhRampOpt) begin
						zhState_r <= spcpb_pkg::SPCPB_ZH_RAMP;
						rampStopReq_r <= 1'b1;
					end else if (zhLvl) begin
						zhState_r <= spcpb_pkg::SPCPB_ZH_LOCK;
						positionLock_r <= 1'b1;
						holdPosition_r <= actualPosition;
					end
				end
				spcpb_pkg::SPCPB_ZH_RAMP: begin
					if (!zhLvl) begin
						zhState_r <= spcpb_pkg::SPCPB_ZH_IDLE;
						rampStopReq_r <= 1'b0;
					end else if (standstill) begin
						zhState_r <= spcpb_pkg::SPCPB_ZH_LOCK;
						rampStopReq_r <= 1'b0;
						positionLock_r <= 1'b1;
						holdPosition_r <= actualPosition;
					end
				end
				spcpb_pkg::SPCPB_ZH_LOCK: begin
					if (!zhLvl) begin
						zhState_r <= spcpb_pkg::SPCPB_ZH_IDLE;
						positionLock_r <= 1'b0;
					end
				end
				default: begin
					zhState_r <= spcpb_pkg::SPCPB_ZH_IDLE;
					rampStopReq_r <= 1'b0;
					positionLock_r <= 1'b0;
				end
			endcase
		end
	end
endmodule

// *** sim/spcpb_bank_props.sv ***
// Port checks for the parameter bank
`timescale 1ns/1ps
module spcpb_bank_props #(
	parameter int OUT_N = 6,
	parameter int DEV_W = 32
) (
	// Clock, reset, access port
	input wire logic clk,
	input wire logic rst,
	input wire logic parWr,
	input wire logic parRd,
	input wire logic [15:0] parAddr,
	input wire logic [31:0] parWdata,
	input wire logic [31:0] parRdata_r,
	input wire logic parAck_r,
	input wire logic parErr_r,
	// Pins and drive state
	input wire logic deviationClearPin,
	input wire logic gearSelLowPin,
	input wire logic gearSelHighPin,
	input wire logic [3:0] opMode,
	input wire logic [15:0] controlModeSelect,
	input wire logic [31:0] gearNumeratorOne,
	input wire logic [OUT_N-1:0] assignedFunc,
	input wire logic [OUT_N-1:0] seqStatus,
	// Outputs
	input wire logic deviationOverflowError_r,
	input wire logic [DEV_W-1:0] positionDeviation_r,
	input wire logic [31:0] activeGearNumerator_r,
	input wire logic [OUT_N-1:0] digitalOutput_r,
	input wire logic positionLock_r,
	input wire logic [31:0] holdPosition_r
);
	logic [31:0] lim_r;
	logic mode_r;
	logic trig_r;
	logic [DEV_W-1:0] absDev;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	assign absDev = positionDeviation_r[DEV_W-1] ? -positionDeviation_r : positionDeviation_r;
	// Mirrors of accepted writes only; refused values never land
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lim_r <= 32'h0005DC00;
			mode_r <= 1'b0;
			trig_r <= 1'b0;
		end else if (parWr) begin
			if (parAddr == 16'h0346 && parWdata != 32'h0 && parWdata <= 32'h00C35000)
				lim_r <= parWdata;
			if (parAddr == 16'h0358 && parWdata <= 32'h1)
				mode_r <= parWdata[0];
			if (parAddr == 16'h0364 && parWdata <= 32'h1)
				trig_r <= parWdata[0];
		end
	end
	property p_limitRange;
		parWr && parAddr == 16'h0346 && (parWdata == 32'h0 || parWdata > 32'h00C35000)
			|=> parAck_r && parErr_r;
	endproperty
	a_limitRange: assert property (p_limitRange) else $error("bad limit accepted");
	property p_pulseFilter;
		parRd && parAddr == 16'h0348 |=> parAck_r && !parErr_r && parRdata_r == 32'h0000001E;
	endproperty
	a_pulseFilter: assert property (p_pulseFilter) else $error("pulse filter read");
	property p_dirFilter;
		parWr && parAddr == 16'h034A |=> parAck_r && parErr_r;
	endproperty
	a_dirFilter: assert property (p_dirFilter) else $error("dir filter written");
	property p_outSel;
		!$past(rst) |-> digitalOutput_r == ($past(mode_r) ? $past(seqStatus) : $past(assignedFunc));
	endproperty
	a_outSel: assert property (p_outSel) else $error("output source wrong");
	property p_overflow;
		(opMode == 4'h1 || opMode == 4'h2) && absDev > lim_r * 32'hA
			|-> ##[0:2] deviationOverflowError_r;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not raised");
	property p_clearLevel;
		(deviationClearPin && trig_r && controlModeSelect == 16'h4001)[*8]
			|-> positionDeviation_r == '0;
	endproperty
	a_clearLevel: assert property (p_clearLevel) else $error("level clear ignored");
	property p_gearOne;
		({gearSelHighPin, gearSelLowPin} == 2'b00 && $stable(gearNumeratorOne))[*8]
			|-> activeGearNumerator_r == gearNumeratorOne;
	endproperty
	a_gearOne: assert property (p_gearOne) else $error("gear one not chosen");
	property p_lockHold;
		positionLock_r && $past(positionLock_r) |-> $stable(holdPosition_r);
	endproperty
	a_lockHold: assert property (p_lockHold) else $error("hold position moved");
endmodule
bind spcpb_bank spcpb_bank_props #(.OUT_N(OUT_N), .DEV_W(DEV_W)) props (
	.clk, .rst, .parWr, .parRd, .parAddr, .parWdata, .parRdata_r, .parAck_r, .parErr_r,
	.deviationClearPin, .gearSelLowPin, .gearSelHighPin, .opMode, .controlModeSelect,
	.gearNumeratorOne, .assignedFunc, .seqStatus, .deviationOverflowError_r,
	.positionDeviation_r, .activeGearNumerator_r, .digitalOutput_r, .positionLock_r,
	.holdPosition_r
);

// *** sim/spcpb_host_model.sv ***
// Host controller model driving the pulse and direction pins
`timescale 1ns/1ps
module spcpb_host_model (
	// Clock
	input wire logic clk,
	// Command pins
	output logic pulseCmdPin,
	output logic dirCmdPin
);
	initial begin
		pulseCmdPin = 1'b0;
		dirCmdPin = 1'b0;
	end
	// Direction settles past the filter before the first edge
	task automatic send(input int n, input logic dir, input int w);
		@(posedge clk);
		#1;
		dirCmdPin = dir;
		repeat (140) @(posedge clk);
		repeat (n) begin
			#1;
			pulseCmdPin = 1'b1;
			repeat (w) @(posedge clk);
			#1;
			pulseCmdPin = 1'b0;
			repeat (w) @(posedge clk);
		end
		#1;
	endtask
endmodule

// *** sim/spcpb_bank_tb.sv ***
// Self-checking bench for the parameter bank
`timescale 1ns/1ps
module spcpb_bank_tb;
	logic clk, rst, parWr, parRd, parAck_r, parErr_r, pulseCmdPin, dirCmdPin;
	logic deviationClearPin, gearSelLowPin, gearSelHighPin, zeroSpeedHoldPin;
	logic fbStep, fbDir, faultReset, standstill, deviationOverflowError_r;
	logic rampStopReq_r, positionLock_r;
	logic [3:0] opMode;
	logic [15:0] parAddr, controlModeSelect;
	logic [31:0] parWdata, parRdata_r, actualPosition, gearNumeratorOne;
	logic [31:0] positionDeviation_r, activeGearNumerator_r, holdPosition_r;
	logic [5:0] assignedFunc, seqStatus, digitalOutput_r;
	int numErrors = 0;
	int comparisons = 0;
	localparam logic [15:0] RA [9] = '{16'h0346, 16'h0348, 16'h034A, 16'h0358, 16'h0364,
		16'h0378, 16'h037A, 16'h037C, 16'h0382};
	localparam logic [31:0] RV [9] = '{32'h0005DC00, 32'h1E, 32'h1E, 32'h0, 32'h0,
		32'h80, 32'h80, 32'h80, 32'h0200};
	localparam logic [31:0] GV [4] = '{32'h44, 32'h11, 32'h22, 32'h33};
	spcpb_host_model host (.clk, .pulseCmdPin, .dirCmdPin);
	spcpb_bank DUT (.clk, .rst, .parWr, .parRd, .parAddr, .parWdata, .parRdata_r, .parAck_r,
		.parErr_r, .pulseCmdPin, .dirCmdPin, .deviationClearPin, .gearSelLowPin,
		.gearSelHighPin, .zeroSpeedHoldPin, .opMode, .controlModeSelect, .fbStep, .fbDir,
		.faultReset, .standstill, .actualPosition, .gearNumeratorOne, .assignedFunc,
		.seqStatus, .deviationOverflowError_r, .positionDeviation_r, .activeGearNumerator_r,
		.digitalOutput_r, .rampStopReq_r, .positionLock_r, .holdPosition_r);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic completeRun;
		$display("errors %0d comparisons %0d", numErrors, comparisons);
		if (numErrors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			numErrors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One access; answer stands exactly one cycle after the strobe
	task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
		input logic err, input logic [31:0] rdExp);
		cyc(1);
		parWr = wr;
		parRd = !wr;
		parAddr = a;
		parWdata = d;
		cyc(1);
		parWr = 1'b0;
		parRd = 1'b0;
		chk(32'(parAck_r), 32'h1);
		chk(32'(parErr_r), 32'(err));
		if (!wr && !err)
			chk(parRdata_r, rdExp);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 9; i++)
			acc(1'b0, RA[i], 32'h0, 1'b0, RV[i]);
		acc(1'b0, 16'h0350, 32'h0, 1'b1, 32'h0);
		acc(1'b1, 16'h0348, 32'h5, 1'b1, 32'h0);
		acc(1'b1, 16'h034A, 32'h5, 1'b1, 32'h0);
		acc(1'b1, 16'h0346, 32'h0, 1'b1, 32'h0);
		acc(1'b1, 16'h0346, 32'h00C35001, 1'b1, 32'h0);
		acc(1'b1, 16'h0346, 32'h00C35000, 1'b0, 32'h0);
		acc(1'b0, 16'h0346, 32'h0, 1'b0, 32'h00C35000);
		acc(1'b1, 16'h037C, 32'h20000000, 1'b1, 32'h0);
		acc(1'b1, 16'h037C, 32'h1FFFFFFF, 1'b0, 32'h0);
		acc(1'b0, 16'h037C, 32'h0, 1'b0, 32'h1FFFFFFF);
		acc(1'b1, 16'h0382, 32'hFFC0, 1'b0, 32'h0);
		acc(1'b0, 16'h0382, 32'h0, 1'b0, 32'hFFC0);
		acc(1'b1, 16'h0382, 32'h0200, 1'b0, 32'h0);
	endtask
	task automatic t_pulses;
		opMode = 4'h1;
		acc(1'b1, 16'h0346, 32'h1, 1'b0, 32'h0);
		host.send(10, 1'b0, 140);
		chk(positionDeviation_r, 32'hA);
		chk(32'(deviationOverflowError_r), 32'h0);
		host.send(1, 1'b0, 60);
		chk(positionDeviation_r, 32'hA);
		host.send(1, 1'b0, 140);
		cyc(3);
		chk(32'(deviationOverflowError_r), 32'h1);
		host.send(2, 1'b1, 140);
		fbStep = 1'b1;
		cyc(1);
		fbStep = 1'b0;
		cyc(2);
		chk(positionDeviation_r, 32'h8);
		chk(32'(deviationOverflowError_r), 32'h1);
		faultReset = 1'b1;
		cyc(1);
		faultReset = 1'b0;
		cyc(2);
		chk(32'(deviationOverflowError_r), 32'h0);
	endtask
	task automatic t_clear;
		deviationClearPin = 1'b1;
		cyc(10);
		deviationClearPin = 1'b0;
		cyc(5);
		chk(positionDeviation_r, 32'h8);
		controlModeSelect = 16'h4001;
		deviationClearPin = 1'b1;
		cyc(10);
		chk(positionDeviation_r, 32'h0);
		host.send(1, 1'b0, 140);
		chk(positionDeviation_r, 32'h1);
		acc(1'b1, 16'h0364, 32'h1, 1'b0, 32'h0);
		cyc(10);
		host.send(1, 1'b0, 140);
		chk(positionDeviation_r, 32'h0);
		deviationClearPin = 1'b0;
	endtask
	task automatic t_outputs;
		assignedFunc = 6'h15;
		seqStatus = 6'h2A;
		cyc(2);
		chk(32'(digitalOutput_r), 32'h15);
		acc(1'b1, 16'h0358, 32'h1, 1'b0, 32'h0);
		cyc(2);
		chk(32'(digitalOutput_r), 32'h2A);
		acc(1'b1, 16'h0358, 32'h2, 1'b1, 32'h0);
		acc(1'b1, 16'h0358, 32'h0, 1'b0, 32'h0);
		cyc(2);
		chk(32'(digitalOutput_r), 32'h15);
	endtask
	task automatic t_gear;
		gearNumeratorOne = GV[0];
		for (int i = 1; i < 4; i++)
			acc(1'b1, 16'(16'h0376 + 2 * i), GV[i], 1'b0, 32'h0);
		for (int s = 0; s < 4; s++) begin
			{gearSelHighPin, gearSelLowPin} = 2'(s);
			cyc(8);
			chk(activeGearNumerator_r, GV[s]);
		end
	endtask
	task automatic t_hold;
		acc(1'b1, 16'h0382, 32'h0600, 1'b0, 32'h0);
		actualPosition = 32'h0000ABCD;
		zeroSpeedHoldPin = 1'b1;
		cyc(10);
		chk(32'({rampStopReq_r, positionLock_r}), 32'h2);
		standstill = 1'b1;
		cyc(10);
		chk(32'({rampStopReq_r, positionLock_r}), 32'h1);
		actualPosition = 32'h00001111;
		cyc(4);
		chk(holdPosition_r, 32'h0000ABCD);
		zeroSpeedHoldPin = 1'b0;
		cyc(4);
		// Option 0: lock at once, no ramp request
		acc(1'b1, 16'h0382, 32'h0200, 1'b0, 32'h0);
		actualPosition = 32'h00002222;
		zeroSpeedHoldPin = 1'b1;
		cyc(8);
		chk(32'({rampStopReq_r, positionLock_r}), 32'h1);
		chk(holdPosition_r, 32'h00002222);
		zeroSpeedHoldPin = 1'b0;
	endtask
	// Monitor must stay quiet outside pulse-train and sequence modes
	task automatic t_modes;
		opMode = 4'h4;
		fbDir = 1'b1;
		fbStep = 1'b1;
		cyc(11);
		fbStep = 1'b0;
		fbDir = 1'b0;
		cyc(3);
		chk(positionDeviation_r, 32'hB);
		chk(32'(deviationOverflowError_r), 32'h0);
		opMode = 4'h2;
		cyc(3);
		chk(32'(deviationOverflowError_r), 32'h1);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		numErrors++;
		completeRun();
	end
	initial begin
		{rst, parWr, parRd, deviationClearPin, gearSelLowPin, gearSelHighPin} = 6'h20;
		{zeroSpeedHoldPin, fbStep, fbDir, faultReset, standstill} = 5'h0;
		{opMode, controlModeSelect, parAddr, parWdata} = '0;
		{actualPosition, gearNumeratorOne, assignedFunc, seqStatus} = '0;
		cyc(8);
		rst = 1'b0;
		t_regs();
		t_pulses();
		t_clear();
		t_outputs();
		t_gear();
		t_hold();
		t_modes();
		completeRun();
	end
endmodule
